/* hw/ermc_pkg.sv */
`default_nettype none
package ermc_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int CNT_W  = 32;

    // Register word indexes on the plain register port.
    localparam logic [3:0] REG_CTRL     = 4'h0;
    localparam logic [3:0] REG_CMD      = 4'h1;
    localparam logic [3:0] REG_STATUS   = 4'h2;
    localparam logic [3:0] REG_IRQ_STAT = 4'h3;
    localparam logic [3:0] REG_IRQ_MASK = 4'h4;
    localparam logic [3:0] REG_RES_BITS = 4'h5;
    localparam logic [3:0] REG_RES_ERRS = 4'h6;
    localparam logic [3:0] REG_CNT_BITS = 4'h7;
    localparam logic [3:0] REG_CNT_ERRS = 4'h8;

    localparam int CTRL_AUTO_BIT = 0;
    localparam int CMD_EXEC_BIT  = 0;

    localparam int IRQ_W         = 3;
    localparam int IRQ_DONE      = 0;
    localparam int IRQ_CLK_LOST  = 1;
    localparam int IRQ_SYNC_LOST = 2;

    localparam int ST_CLK_LSB  = 0;
    localparam int ST_DATA_LSB = 2;
    localparam int ST_SYNC_LSB = 4;
    localparam int ST_RUN_BIT  = 6;
    localparam int ST_FIRST_BIT = 7;
    localparam int ST_DONE_BIT = 8;

    localparam int SYS_CLK_MHZ  = 200;
    localparam int CLK_DET_NS   = 1000;
    localparam int DATA_DET_NS  = 20000;
    localparam int UPD_US       = 1000;
    localparam int CLK_DET_CYC  = CLK_DET_NS * SYS_CLK_MHZ / 1000;
    localparam int DATA_DET_CYC = DATA_DET_NS * SYS_CLK_MHZ / 1000;
    localparam int UPD_CYC      = UPD_US * SYS_CLK_MHZ;
    localparam int TMR_W        = 24;

    typedef enum logic [1:0] {
        ERMC_LVL_OK    = 2'h1,
        ERMC_LVL_MISS  = 2'h2,
        ERMC_LVL_FAULT = 2'h3
    } ermc_lvl_t;

    typedef enum logic [2:0] {
        ERMC_IDLE = 3'h1,
        ERMC_RUN  = 3'h2,
        ERMC_DONE = 3'h4
    } ermc_state_t;

    typedef struct packed {
        logic [CNT_W-1:0] bits;
        logic [CNT_W-1:0] errs;
    } ermc_cnt_t;

    typedef struct packed {
        ermc_lvl_t clk;
        ermc_lvl_t data;
        ermc_lvl_t sync;
    } ermc_lvl_set_t;

endpackage
`default_nettype wire

/* hw/ermc_top.sv */
// Behaviour
// RULE_01 - Auto mode ends a run on termination and restarts at once.
// RULE_02 - Auto results publish periodically in the first run only and at every termination, counts track live.
// RULE_03 - An execute command starts exactly one run and only in single mode.
// RULE_04 - Single mode refreshes results and counts periodically in a run.
// RULE_05 - Single mode stops a run on termination and never restarts it.
// RULE_06 - A clock-present flag shows activity on the measurement clock pin.
// RULE_07 - A data-present flag shows activity on the measurement data input.
// RULE_08 - A sync flag is set while locked to the incoming data sequence.
// RULE_09 - Sync is never declared before clock and data are both present.
// RULE_10 - Each status indication reads as correct, missing or faulty.
// RULE_11 - After a single run, results and counts hold until the next execute.
`timescale 1ns/1ps
`default_nettype none
module ermc_top #(
    parameter int UPD_CYCLES = ermc_pkg::UPD_CYC
) (
    input  wire logic                        sys_clk,
    input  wire logic                        rstn,
    input  wire logic [ermc_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [ermc_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [ermc_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic                        meas_clk,
    input  wire logic                        meas_data,
    input  wire logic                        sync_lock,
    input  wire logic                        term_hit,
    input  wire ermc_pkg::ermc_cnt_t         live,
    output logic                             run_start,
    output logic                             run_active,
    output logic                             irq
);
    import ermc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, a level counts once stages two and
    // three agree, so a glitch of one sample never makes an edge.
    logic [2:0] ck_sh;
    logic [2:0] dt_sh;
    logic       ck_f;
    logic       dt_f;
    logic       next_ck_f;
    logic       next_dt_f;
    logic       ck_edge;
    logic       dt_edge;

    always_comb begin
        next_ck_f = (ck_sh[1] == ck_sh[2]) ? ck_sh[2] : ck_f;
        next_dt_f = (dt_sh[1] == dt_sh[2]) ? dt_sh[2] : dt_f;
        ck_edge   = next_ck_f != ck_f;
        dt_edge   = next_dt_f != dt_f;
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ck_sh <= 3'h0;
            dt_sh <= 3'h0;
            ck_f  <= 1'b0;
            dt_f  <= 1'b0;
        end else begin
            ck_sh <= {ck_sh[1:0], meas_clk};
            dt_sh <= {dt_sh[1:0], meas_data};
            ck_f  <= next_ck_f;
            dt_f  <= next_dt_f;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Activity detectors and status levels.
    localparam logic [TMR_W-1:0] CK_RELOAD = TMR_W'(CLK_DET_CYC);
    localparam logic [TMR_W-1:0] DT_RELOAD = TMR_W'(DATA_DET_CYC);
    localparam logic [TMR_W-1:0] TMR_ONE   = 24'h000001;

    logic [TMR_W-1:0] ck_tmr;
    logic [TMR_W-1:0] dt_tmr;
    logic [TMR_W-1:0] next_ck_tmr;
    logic [TMR_W-1:0] next_dt_tmr;
    logic             clk_ok;
    logic             data_ok;
    logic             sync_ok;
    logic             next_clk_ok;
    logic             next_data_ok;
    logic             next_sync_ok;
    ermc_lvl_set_t    lvl;
    ermc_lvl_set_t    next_lvl;

    always_comb begin
        next_ck_tmr = ck_edge ? CK_RELOAD :
                      (ck_tmr != '0) ? ck_tmr - TMR_ONE : ck_tmr;
        next_dt_tmr = dt_edge ? DT_RELOAD :
                      (dt_tmr != '0) ? dt_tmr - TMR_ONE : dt_tmr;
        next_clk_ok  = ck_edge | (ck_tmr > TMR_ONE);              // [RULE_06]
        next_data_ok = dt_edge | (dt_tmr > TMR_ONE);              // [RULE_07]
        next_sync_ok = sync_lock & clk_ok & data_ok;   // [RULE_08] [RULE_09]
        next_lvl.clk = clk_ok ? ERMC_LVL_OK : ERMC_LVL_MISS;      // [RULE_10]
        // Data toggling with no clock cannot be sampled, hence faulty.
        if (!data_ok) begin
            next_lvl.data = ERMC_LVL_MISS;                        // [RULE_10]
        end else begin
            next_lvl.data = clk_ok ? ERMC_LVL_OK : ERMC_LVL_FAULT;
        end
        if (sync_ok) begin
            next_lvl.sync = ERMC_LVL_OK;                          // [RULE_10]
        end else begin
            next_lvl.sync = (clk_ok & data_ok) ? ERMC_LVL_FAULT
                                               : ERMC_LVL_MISS;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ck_tmr  <= '0;
            dt_tmr  <= '0;
            clk_ok  <= 1'b0;
            data_ok <= 1'b0;
            sync_ok <= 1'b0;
            lvl     <= '{ERMC_LVL_MISS, ERMC_LVL_MISS, ERMC_LVL_MISS};
        end else begin
            ck_tmr  <= next_ck_tmr;
            dt_tmr  <= next_dt_tmr;
            clk_ok  <= next_clk_ok;
            data_ok <= next_data_ok;
            sync_ok <= next_sync_ok;
            lvl     <= next_lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Run control and result publishing.
    logic        ctrl_auto;
    logic        exec_req;
    ermc_state_t state;
    ermc_state_t next_state;
    logic        first_run;
    logic        next_first_run;
    logic        next_run_start;
    logic [31:0] upd_cnt;
    logic [31:0] next_upd_cnt;
    logic        upd_tick;
    ermc_cnt_t   res;
    ermc_cnt_t   cnt;
    ermc_cnt_t   next_res;
    ermc_cnt_t   next_cnt;

    assign exec_req = reg_wr && reg_addr == REG_CMD &&
                      reg_wdata[CMD_EXEC_BIT] && !ctrl_auto;
    assign upd_tick = upd_cnt == 32'(UPD_CYCLES - 1);

    always_comb begin
        next_state     = state;
        next_first_run = first_run;
        next_run_start = 1'b0;
        next_upd_cnt   = upd_tick ? 32'h0 : upd_cnt + 32'h1;
        next_res       = res;
        next_cnt       = cnt;
        unique case (state)
            ERMC_IDLE, ERMC_DONE: begin
                next_upd_cnt = 32'h0;
                // A finished single run holds its figures here.
                if (ctrl_auto || exec_req) begin      // [RULE_03] [RULE_11]
                    next_state     = ERMC_RUN;
                    next_run_start = 1'b1;
                    next_first_run = 1'b1;
                end
            end
            ERMC_RUN: begin
                if (ctrl_auto) begin
                    next_cnt = live;                              // [RULE_02]
                    if (term_hit || (first_run && upd_tick)) begin
                        next_res = live;                          // [RULE_02]
                    end
                    if (term_hit) begin
                        next_run_start = 1'b1;                    // [RULE_01]
                        next_first_run = 1'b0;
                        next_upd_cnt   = 32'h0;
                    end
                end else begin
                    if (upd_tick || term_hit) begin
                        next_res = live;                          // [RULE_04]
                        next_cnt = live;
                    end
                    if (term_hit) begin
                        next_state = ERMC_DONE;                   // [RULE_05]
                    end
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state      <= ERMC_IDLE;
            first_run  <= 1'b0;
            run_start  <= 1'b0;
            run_active <= 1'b0;
            upd_cnt    <= 32'h0;
            res        <= '0;
            cnt        <= '0;
        end else begin
            state      <= next_state;
            first_run  <= next_first_run;
            run_start  <= next_run_start;
            run_active <= next_state == ERMC_RUN;
            upd_cnt    <= next_upd_cnt;
            res        <= next_res;
            cnt        <= next_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register port and interrupt. A hardware set beats a software clear
    // in the same cycle so that no event is lost.
    logic [IRQ_W-1:0]  irq_stat;
    logic [IRQ_W-1:0]  irq_mask;
    logic [IRQ_W-1:0]  irq_set;
    logic [IRQ_W-1:0]  irq_clr;
    logic [IRQ_W-1:0]  next_irq_stat;
    logic [IRQ_W-1:0]  next_irq_mask;
    logic              next_ctrl_auto;
    logic [DATA_W-1:0] next_rdata;
    logic [DATA_W-1:0] status_word;

    always_comb begin
        status_word = '0;
        status_word[ST_CLK_LSB +: 2]  = lvl.clk;
        status_word[ST_DATA_LSB +: 2] = lvl.data;
        status_word[ST_SYNC_LSB +: 2] = lvl.sync;
        status_word[ST_RUN_BIT]       = state == ERMC_RUN;
        status_word[ST_FIRST_BIT]     = first_run;
        status_word[ST_DONE_BIT]      = state == ERMC_DONE;
        irq_set = '0;
        irq_set[IRQ_DONE]      = state == ERMC_RUN && term_hit;
        irq_set[IRQ_CLK_LOST]  = clk_ok && !next_clk_ok;
        irq_set[IRQ_SYNC_LOST] = sync_ok && !next_sync_ok;
        irq_clr = (reg_wr && reg_addr == REG_IRQ_STAT) ?
                  reg_wdata[IRQ_W-1:0] : '0;
        next_irq_stat  = (irq_stat & ~irq_clr) | irq_set;
        next_irq_mask  = (reg_wr && reg_addr == REG_IRQ_MASK) ?
                         reg_wdata[IRQ_W-1:0] : irq_mask;
        next_ctrl_auto = (reg_wr && reg_addr == REG_CTRL) ?
                         reg_wdata[CTRL_AUTO_BIT] : ctrl_auto;
        next_rdata = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                REG_CTRL:     next_rdata[CTRL_AUTO_BIT] = ctrl_auto;
                REG_STATUS:   next_rdata = status_word;
                REG_IRQ_STAT: next_rdata[IRQ_W-1:0] = irq_stat;
                REG_IRQ_MASK: next_rdata[IRQ_W-1:0] = irq_mask;
                REG_RES_BITS: next_rdata = res.bits;
                REG_RES_ERRS: next_rdata = res.errs;
                REG_CNT_BITS: next_rdata = cnt.bits;
                REG_CNT_ERRS: next_rdata = cnt.errs;
                default:      next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ctrl_auto <= 1'b0;
            irq_stat  <= '0;
            irq_mask  <= '0;
            reg_rdata <= '0;
            irq       <= 1'b0;
        end else begin
            ctrl_auto <= next_ctrl_auto;
            irq_stat  <= next_irq_stat;
            irq_mask  <= next_irq_mask;
            reg_rdata <= next_rdata;
            irq       <= |(next_irq_stat & next_irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_auto_restart: assert property ( // [RULE_01]
        @(posedge sys_clk) disable iff (!rstn)
        state == ERMC_RUN && ctrl_auto && term_hit |=>
            run_start && state == ERMC_RUN && !first_run)
        else $error("auto run did not restart on termination");
    a_auto_final: assert property ( // [RULE_02]
        @(posedge sys_clk) disable iff (!rstn)
        state == ERMC_RUN && ctrl_auto && !first_run && !term_hit |=>
            $stable(res) && cnt == $past(live))
        else $error("auto later run published early or counts stale");
    a_single_start: assert property ( // [RULE_03]
        @(posedge sys_clk) disable iff (!rstn)
        exec_req && state != ERMC_RUN |=> run_start ##1 !run_start)
        else $error("execute did not start exactly one run");
    a_auto_no_exec: assert property ( // [RULE_03]
        @(posedge sys_clk) disable iff (!rstn)
        state == ERMC_RUN && !term_hit |=> !run_start)
        else $error("run started without cause");
    a_single_update: assert property ( // [RULE_04]
        @(posedge sys_clk) disable iff (!rstn)
        state == ERMC_RUN && !ctrl_auto && upd_tick |=>
            res == $past(live) && cnt == $past(live))
        else $error("periodic update missing in single run");
    a_single_stop: assert property ( // [RULE_05]
        @(posedge sys_clk) disable iff (!rstn)
        state == ERMC_RUN && !ctrl_auto && term_hit |=>
            state == ERMC_DONE && !run_start)
        else $error("single run did not stop on termination");
    a_clk_present: assert property ( // [RULE_06]
        @(posedge sys_clk) disable iff (!rstn)
        ck_edge |=> clk_ok [*2])
        else $error("clock flag not set after clock edge");
    a_data_absent: assert property ( // [RULE_07]
        @(posedge sys_clk) disable iff (!rstn)
        dt_tmr == '0 && !dt_edge |=> !data_ok)
        else $error("data flag stays set with no activity");
    a_sync_flag: assert property ( // [RULE_08]
        @(posedge sys_clk) disable iff (!rstn)
        !sync_lock |=> !sync_ok)
        else $error("sync flag set while unlocked");
    a_sync_gate: assert property ( // [RULE_09]
        @(posedge sys_clk) disable iff (!rstn)
        sync_ok |-> $past(clk_ok) && $past(data_ok))
        else $error("sync declared without clock and data");
    a_level_code: assert property ( // [RULE_10]
        @(posedge sys_clk) disable iff (!rstn)
        !clk_ok |=> lvl.clk == ERMC_LVL_MISS ##1 lvl.sync != ERMC_LVL_OK)
        else $error("status level wrong for missing clock");
    a_hold_done: assert property ( // [RULE_11]
        @(posedge sys_clk) disable iff (!rstn)
        state == ERMC_DONE && !exec_req && !ctrl_auto |=>
            $stable(res) && $stable(cnt) && state == ERMC_DONE)
        else $error("final results changed after single run");

endmodule
`default_nettype wire

/* tb/ermc_dut_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ermc_dut_model (
    input  wire logic clk_en,
    input  wire logic data_en,
    output logic      meas_clk,
    output logic      meas_data
);
    logic [8:0] lfsr;

    initial begin
        meas_clk  = 1'b0;
        meas_data = 1'b0;
        lfsr      = 9'h1FF;
    end

    // The clock parks low when disabled, so a lost clock looks like a dead pin.
    always begin
        #62.5;
        meas_clk = clk_en ? ~meas_clk : 1'b0;
    end

    // Data launches on the falling edge to sit stable around the rising edge.
    always @(negedge meas_clk) begin
        if (data_en) begin
            lfsr      = {lfsr[7:0], lfsr[8] ^ lfsr[4]};
            meas_data = lfsr[0];
        end else begin
            meas_data = 1'b0;
        end
    end
endmodule
`default_nettype wire

/* tb/ermc_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
module ermc_top_test;
    import ermc_pkg::*;

    localparam int UPD   = 50;
    localparam int LIMIT = 20000;

    logic              sys_clk;
    logic              rstn;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    wire logic         meas_clk;
    wire logic         meas_data;
    logic              sync_lock;
    logic              term_hit;
    ermc_cnt_t         live;
    logic              run_start;
    logic              run_active;
    logic              irq;
    logic              clk_en;
    logic              data_en;
    int                failures;
    int                tests_run;
    int                cycles;

    ermc_top #(.UPD_CYCLES(UPD)) uut (
        .sys_clk    (sys_clk),
        .rstn       (rstn),
        .reg_addr   (reg_addr),
        .reg_wdata  (reg_wdata),
        .reg_wr     (reg_wr),
        .reg_rd     (reg_rd),
        .reg_rdata  (reg_rdata),
        .meas_clk   (meas_clk),
        .meas_data  (meas_data),
        .sync_lock  (sync_lock),
        .term_hit   (term_hit),
        .live       (live),
        .run_start  (run_start),
        .run_active (run_active),
        .irq        (irq)
    );

    ermc_dut_model far_end (
        .clk_en    (clk_en),
        .data_en   (data_en),
        .meas_clk  (meas_clk),
        .meas_data (meas_data)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            final_report;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask

    // Reads and compares under a mask; data are valid only the cycle after.
    task automatic rc(input logic [ADDR_W-1:0] a, input logic [31:0] m,
                      input logic [31:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata & m, exp);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic term;
        @(posedge sys_clk);
        term_hit <= 1'b1;
        @(posedge sys_clk);
        term_hit <= 1'b0;
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0; reg_addr = '0; reg_wdata = '0; reg_wr = 1'b0;
        reg_rd = 1'b0; sync_lock = 1'b1; term_hit = 1'b0; live = '0;
        clk_en = 1'b0; data_en = 1'b0; failures = 0; tests_run = 0;
        cycles = 0;
        wait_cyc(10);
        rstn <= 1'b1;
        rc(REG_STATUS, 32'h1FF, 32'h02A);
        rc(REG_CTRL, 32'hFFFFFFFF, 32'h0);
        rc(REG_IRQ_MASK, 32'hFFFFFFFF, 32'h0);
        rc(4'hF, 32'hFFFFFFFF, 32'h0);
        // Link detection and level codes.
        clk_en = 1'b1;
        wait_cyc(60);
        rc(REG_STATUS, 32'h3F, 32'h29);
        sync_lock <= 1'b0;
        data_en = 1'b1;
        wait_cyc(150);
        rc(REG_STATUS, 32'h3F, 32'h35);
        sync_lock <= 1'b1;
        wait_cyc(4);
        rc(REG_STATUS, 32'h3F, 32'h15);
        wr(REG_IRQ_STAT, 32'h7);
        wr(REG_IRQ_MASK, 32'h2);
        clk_en = 1'b0;
        wait_cyc(300);
        rc(REG_STATUS, 32'h3F, 32'h2E);
        rc(REG_IRQ_STAT, 32'h7, 32'h6);
        chk({31'h0, irq}, 32'h1);
        wr(REG_IRQ_STAT, 32'h2);
        wait_cyc(2);
        chk({31'h0, irq}, 32'h0);
        // Single run.
        wr(REG_IRQ_STAT, 32'h7);
        wr(REG_IRQ_MASK, 32'h1);
        live <= '{bits: 32'h00000100, errs: 32'h00000011};
        wr(REG_CMD, 32'h1);
        #1;
        chk({31'h0, run_start}, 32'h1);
        chk({31'h0, run_active}, 32'h1);
        wr(REG_CMD, 32'h1);
        #1;
        chk({31'h0, run_start}, 32'h0);
        wait_cyc(UPD + 10);
        rc(REG_RES_BITS, 32'hFFFFFFFF, 32'h00000100);
        rc(REG_CNT_ERRS, 32'hFFFFFFFF, 32'h00000011);
        live <= '{bits: 32'h00000200, errs: 32'h00000022};
        wait_cyc(2);
        term;
        chk({31'h0, run_active}, 32'h0);
        wait_cyc(2);
        chk({31'h0, irq}, 32'h1);
        rc(REG_STATUS, 32'h140, 32'h100);
        live <= '{bits: 32'h00000300, errs: 32'h00000033};
        wait_cyc(UPD + 10);
        chk({31'h0, run_active}, 32'h0);
        rc(REG_RES_BITS, 32'hFFFFFFFF, 32'h00000200);
        rc(REG_RES_ERRS, 32'hFFFFFFFF, 32'h00000022);
        rc(REG_CNT_BITS, 32'hFFFFFFFF, 32'h00000200);
        wr(REG_IRQ_STAT, 32'h1);
        wait_cyc(2);
        chk({31'h0, irq}, 32'h0);
        // Continuous runs.
        live <= '{bits: 32'h00000400, errs: 32'h00000044};
        // The mode bit lands one cycle after the write; the run starts a
        // cycle later still.
        wr(REG_CTRL, 32'h1);
        wait_cyc(1);
        #1;
        chk({31'h0, run_start}, 32'h1);
        wait_cyc(UPD + 10);
        rc(REG_RES_BITS, 32'hFFFFFFFF, 32'h00000400);
        rc(REG_STATUS, 32'h1C0, 32'h0C0);
        term;
        chk({31'h0, run_start}, 32'h1);
        live <= '{bits: 32'h00000500, errs: 32'h00000055};
        wait_cyc(UPD + 10);
        chk({31'h0, run_active}, 32'h1);
        rc(REG_STATUS, 32'h1C0, 32'h040);
        rc(REG_RES_BITS, 32'hFFFFFFFF, 32'h00000400);
        rc(REG_CNT_BITS, 32'hFFFFFFFF, 32'h00000500);
        rc(REG_CNT_ERRS, 32'hFFFFFFFF, 32'h00000055);
        wr(REG_CTRL, 32'h0);
        term;
        chk({31'h0, run_start}, 32'h0);
        chk({31'h0, run_active}, 32'h0);
        final_report;
    end
endmodule
`default_nettype wire
